// *** rtl/spc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"

// Behaviour
// RULE_01: output pin enable clear: shared data pin reads, output pin stays undriven.
// RULE_02: output pin enable set: writes on data pin, reads only on output pin.
// RULE_03: bit order clear: shift MSB first, address decrements per byte.
// RULE_04: bit order set: shift LSB first, address increments per byte.
// RULE_05: in I2C mode bit order and output pin enable have no effect.
// RULE_06: soft reset restores defaults, clears itself on next serial clock.
// RULE_07: soft reset leaves the setup byte fields untouched.
// RULE_08: in I2C mode soft reset behaves alike, clearing on next clock.
// RULE_09: host writes the low nibble as the reversed upper nibble.
// RULE_10: read-only silicon revision byte at address 2, writes ignored.
// RULE_11: read-only variant code byte at address 3.
// RULE_12: bank select bit 0 picks buffer or active copy for readback; the code reads bit 0 back as the OR of the active and buffer copies.
// RULE_13: buffer copy becomes active only on an update strobe.
module spc_regs
	import spc_pkg::*;
#(
	// arbitrary identification values
	parameter spc_byte_type REV_CODE = 8'h5A,
	parameter spc_byte_type VARIANT_CODE = 8'h3C
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdio_in,
	input wire logic i2c_mode,
	input wire logic io_update,
	output logic sdio_out,
	output logic sdio_oe,
	output logic serial_output_pin_out,
	output logic serial_output_pin_oe,
	output logic [7:0] setup_byte,
	output logic bank_active,
	output logic soft_reset_pulse
);

	logic [4:0] pin_raw;
	logic [4:0] pin_lvl;
	logic [4:0] prev_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic csb_act;
	logic sdio_lvl;
	logic i2c_lvl;
	logic upd_rise;

	assign pin_raw = {io_update, i2c_mode, sdio_in, csb_n, sclk};

	spc_sync #(
		.RST_VAL(`SPC_PIN_RST)
	) u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.pin_raw(pin_raw),
		.pin_lvl(pin_lvl)
	);

	assign sclk_rise = pin_lvl[0] & ~prev_reg[0];
	assign sclk_fall = ~pin_lvl[0] & prev_reg[0];
	assign csb_act = ~pin_lvl[1];
	assign sdio_lvl = pin_lvl[2];
	assign i2c_lvl = pin_lvl[3];
	assign upd_rise = pin_lvl[4] & ~prev_reg[4];

	spc_state_type state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [15:0] instr_reg, instr_next;
	spc_addr_type addr_reg, addr_next;
	logic rd_reg, rd_next;
	spc_byte_type shin_reg, shin_next;
	spc_byte_type out_byte_reg, out_byte_next;
	logic dout_reg, dout_next;
	logic sdio_oe_reg, sdio_oe_next;
	logic outpin_oe_reg, outpin_oe_next;
	spc_byte_type setup_reg, setup_next;
	logic bank_buf_reg, bank_buf_next;
	logic bank_act_reg, bank_act_next;
	logic soft_pend_reg, soft_pend_next;
	logic soft_pulse_reg, soft_pulse_next;

	logic lsb_eff;
	logic out_en_eff;
	logic [15:0] instr_word;
	spc_byte_type shin_word;
	spc_addr_type addr_step;
	logic instr_done;
	logic byte_end;

	// I2C has no bit order or output pin choice
	assign lsb_eff = setup_reg[`SPC_BIT_LSB_FIRST] & ~i2c_lvl; // RULE_05
	assign out_en_eff = setup_reg[`SPC_BIT_OUT_EN] & ~i2c_lvl; // RULE_05

	assign instr_word = lsb_eff ? {sdio_lvl, instr_reg[15:1]} :
		{instr_reg[14:0], sdio_lvl};
	assign shin_word = lsb_eff ? {sdio_lvl, shin_reg[7:1]} :
		{shin_reg[6:0], sdio_lvl};
	// RULE_03 RULE_04
	assign addr_step = lsb_eff ? addr_reg + 13'h0001 : addr_reg - 13'h0001;
	assign instr_done = state_reg == SPC_INSTR && sclk_rise &&
		cnt_reg == `SPC_INSTR_LAST;
	assign byte_end = state_reg == SPC_DATA && sclk_rise &&
		cnt_reg == `SPC_BYTE_LAST;

	// unmapped addresses read as zero
	function automatic spc_byte_type rd_byte(input spc_addr_type addr,
		input spc_byte_type setup, input logic buf_bit,
		input logic act_bit);
		begin
			case (addr)
			`SPC_ADDR_SETUP: rd_byte = setup;
			`SPC_ADDR_REV: rd_byte = REV_CODE; // RULE_10
			`SPC_ADDR_VARIANT: rd_byte = VARIANT_CODE; // RULE_11
			`SPC_ADDR_BANK: rd_byte = {7'h00, act_bit ? act_bit : buf_bit}; // RULE_12
			default: rd_byte = 8'h00;
			endcase
		end
	endfunction

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		instr_next = instr_reg;
		addr_next = addr_reg;
		rd_next = rd_reg;
		shin_next = shin_reg;
		out_byte_next = out_byte_reg;
		dout_next = dout_reg;
		sdio_oe_next = sdio_oe_reg;
		outpin_oe_next = outpin_oe_reg;
		setup_next = setup_reg;
		bank_buf_next = bank_buf_reg;
		bank_act_next = bank_act_reg;
		soft_pend_next = soft_pend_reg;
		soft_pulse_next = 1'b0;
		if (upd_rise) begin
			bank_act_next = bank_buf_reg; // RULE_13
		end
		if (!csb_act) begin
			state_next = SPC_IDLE;
			sdio_oe_next = 1'b0;
			outpin_oe_next = 1'b0;
		end else begin
			case (state_reg)
			SPC_IDLE: begin
				state_next = SPC_INSTR;
				cnt_next = 4'h0;
			end
			SPC_INSTR: begin
				if (sclk_rise) begin
					instr_next = instr_word;
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == `SPC_INSTR_LAST) begin
						rd_next = instr_word[`SPC_INSTR_RW];
						addr_next = instr_word[`SPC_INSTR_ADDR_MSB:0];
						state_next = SPC_DATA;
						out_byte_next = rd_byte(
							instr_word[`SPC_INSTR_ADDR_MSB:0],
							setup_reg, bank_buf_reg, bank_act_reg);
					end
				end
			end
			SPC_DATA: begin
				if (sclk_rise) begin
					shin_next = shin_word;
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == `SPC_BYTE_LAST) begin
						cnt_next = 4'h0;
						addr_next = addr_step; // RULE_03 RULE_04
						out_byte_next = rd_byte(addr_step, setup_reg,
							bank_buf_reg, bank_act_reg);
						if (!rd_reg && addr_reg == `SPC_ADDR_SETUP) begin
							setup_next = shin_word;
							soft_pend_next = shin_word[`SPC_BIT_SOFT_RST];
						end
						if (!rd_reg && addr_reg == `SPC_ADDR_BANK) begin
							bank_buf_next = shin_word[`SPC_BIT_BANK];
						end
					end
				end
				// read data changes on the falling edge, host samples late in the high phase
				if (sclk_fall && rd_reg) begin
					dout_next = lsb_eff ? out_byte_reg[cnt_reg[2:0]] :
						out_byte_reg[3'h7 - cnt_reg[2:0]]; // RULE_03 RULE_04
					outpin_oe_next = out_en_eff; // RULE_01 RULE_02
					sdio_oe_next = ~out_en_eff; // RULE_01 RULE_02
				end
			end
			default: begin
				state_next = SPC_IDLE;
			end
			endcase
		end
		// the setup byte itself is spared; only bit 5 and its mirror drop
		if (soft_pend_reg && sclk_rise) begin
			soft_pend_next = 1'b0; // RULE_06 RULE_08
			soft_pulse_next = 1'b1;
			setup_next[`SPC_BIT_SOFT_RST] = 1'b0; // RULE_07
			setup_next[`SPC_BIT_SOFT_MIRROR] = 1'b0;
			bank_buf_next = `SPC_BANK_RST; // RULE_06
			bank_act_next = `SPC_BANK_RST;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prev_reg <= `SPC_PIN_RST;
			state_reg <= SPC_IDLE;
			cnt_reg <= 4'h0;
			instr_reg <= 16'h0000;
			addr_reg <= 13'h0000;
			rd_reg <= 1'b0;
			shin_reg <= 8'h00;
			out_byte_reg <= 8'h00;
			dout_reg <= 1'b0;
			sdio_oe_reg <= 1'b0;
			outpin_oe_reg <= 1'b0;
			setup_reg <= `SPC_SETUP_RST;
			bank_buf_reg <= `SPC_BANK_RST;
			bank_act_reg <= `SPC_BANK_RST;
			soft_pend_reg <= 1'b0;
			soft_pulse_reg <= 1'b0;
		end else begin
			prev_reg <= pin_lvl;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			instr_reg <= instr_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			shin_reg <= shin_next;
			out_byte_reg <= out_byte_next;
			dout_reg <= dout_next;
			sdio_oe_reg <= sdio_oe_next;
			outpin_oe_reg <= outpin_oe_next;
			setup_reg <= setup_next;
			bank_buf_reg <= bank_buf_next;
			bank_act_reg <= bank_act_next;
			soft_pend_reg <= soft_pend_next;
			soft_pulse_reg <= soft_pulse_next;
		end
	end

	assign sdio_out = dout_reg;
	assign sdio_oe = sdio_oe_reg;
	assign serial_output_pin_out = dout_reg;
	assign serial_output_pin_oe = outpin_oe_reg;
	assign setup_byte = setup_reg;
	assign bank_active = bank_act_reg;
	assign soft_reset_pulse = soft_pulse_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence s_soft_arm;
		soft_pend_reg && sclk_rise;
	endsequence

	sequence s_read_fall;
		state_reg == SPC_DATA && rd_reg && sclk_fall && csb_act;
	endsequence

	a_outpin_hiz: assert property ($rose(outpin_oe_reg) |-> // RULE_01
		$past(out_en_eff))
		else $error("output pin driven while its enable is clear");

	a_sdio_quiet: assert property ($rose(sdio_oe_reg) |-> // RULE_02
		!$past(out_en_eff))
		else $error("data pin driven in unidirectional mode");

	a_read_pin_pick: assert property (s_read_fall ##0 out_en_eff |=> // RULE_02
		outpin_oe_reg && !sdio_oe_reg)
		else $error("read data not on output pin");

	a_msb_step: assert property (byte_end && !lsb_eff |=> // RULE_03
		addr_reg == $past(addr_reg) - 13'h0001)
		else $error("address did not decrement");

	a_lsb_step: assert property (byte_end && lsb_eff |=> // RULE_04
		addr_reg == $past(addr_reg) + 13'h0001)
		else $error("address did not increment");

	a_i2c_order: assert property (i2c_lvl && byte_end |=> // RULE_05
		addr_reg == $past(addr_reg) - 13'h0001)
		else $error("bit order honoured in I2C mode");

	a_soft_clear: assert property (s_soft_arm |=> // RULE_06
		!setup_reg[`SPC_BIT_SOFT_RST] && soft_reset_pulse ##1 !soft_reset_pulse)
		else $error("soft reset did not clear itself");

	a_soft_keep: assert property (s_soft_arm |=> // RULE_07
		setup_reg[7:6] == $past(setup_reg[7:6]) && !bank_act_reg)
		else $error("soft reset disturbed the setup byte");

	a_rev_read: assert property (instr_done && // RULE_10
		instr_word[`SPC_INSTR_ADDR_MSB:0] == `SPC_ADDR_REV |=>
		out_byte_reg == REV_CODE)
		else $error("revision byte wrong");

	a_variant_read: assert property (instr_done && // RULE_11
		instr_word[`SPC_INSTR_ADDR_MSB:0] == `SPC_ADDR_VARIANT |=>
		out_byte_reg == VARIANT_CODE)
		else $error("variant byte wrong");

	a_bank_read: assert property (instr_done && // RULE_12
		instr_word[`SPC_INSTR_ADDR_MSB:0] == `SPC_ADDR_BANK |=>
		out_byte_reg[0] == ($past(bank_act_reg) ? 1'b1 : $past(bank_buf_reg)))
		else $error("bank select readback from wrong copy");

	a_bank_update: assert property (upd_rise && // RULE_13
		!(soft_pend_reg && sclk_rise) |=>
		bank_act_reg == $past(bank_buf_reg))
		else $error("update did not copy buffer to active");

endmodule

`default_nettype wire

// *** rtl/spc_cfg.svh ***
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// register addresses of the serial port block
`define SPC_ADDR_SETUP 13'h0000
`define SPC_ADDR_REV 13'h0002
`define SPC_ADDR_VARIANT 13'h0003
`define SPC_ADDR_BANK 13'h0004

// field positions inside the setup byte and the bank select byte
`define SPC_BIT_OUT_EN 7
`define SPC_BIT_LSB_FIRST 6
`define SPC_BIT_SOFT_RST 5
`define SPC_BIT_SOFT_MIRROR 2
`define SPC_BIT_BANK 0

// instruction word layout: read flag, byte count, register address
`define SPC_INSTR_RW 15
`define SPC_INSTR_ADDR_MSB 12

// reset values
`define SPC_SETUP_RST 8'h00
`define SPC_BANK_RST 1'b0
`define SPC_PIN_RST 5'h02

// frame timing counts, in serial clock edges
`define SPC_INSTR_LAST 4'hF
`define SPC_BYTE_LAST 4'h7

`endif

// *** rtl/spc_pkg.sv ***
package spc_pkg;

	typedef enum logic [1:0] {
		SPC_IDLE = 2'b00,
		SPC_INSTR = 2'b01,
		SPC_DATA = 2'b10
	} spc_state_type;

	typedef logic [7:0] spc_byte_type;
	typedef logic [12:0] spc_addr_type;

endpackage

// *** rtl/spc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module spc_sync #(
	parameter logic [4:0] RST_VAL = 5'h00
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [4:0] pin_raw,
	output logic [4:0] pin_lvl
);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic lvl_reg;
			logic lvl_next;

			// a change is taken only once the second and third stages agree
			always_comb begin
				lvl_next = lvl_reg;
				if (s2_reg == s3_reg) begin
					lvl_next = s3_reg;
				end
			end

			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					s1_reg <= RST_VAL[gi];
					s2_reg <= RST_VAL[gi];
					s3_reg <= RST_VAL[gi];
					lvl_reg <= RST_VAL[gi];
				end else begin
					s1_reg <= pin_raw[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					lvl_reg <= lvl_next;
				end
			end

			assign pin_lvl[gi] = lvl_reg;
		end
	endgenerate

endmodule

`default_nettype wire

// *** tb/spc_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module spc_host (
	input wire logic mclk,
	output logic sclk,
	output logic csb_n,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic so_out,
	input wire logic so_oe
);
	logic drv = 1'b0;
	logic wbit = 1'b0;
	logic sd_last = 1'b0;
	logic so_last = 1'b0;
	logic so_line;

	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
	end

	// an undriven line has no pull, so it keeps flipping
	always @(posedge mclk) begin
		sd_last <= (sdio_in === 1'b1);
		so_last <= (so_line === 1'b1);
	end
	assign sdio_in = sdio_oe ? sdio_out : (drv ? wbit : ~sd_last);
	assign so_line = so_oe ? so_out : ~so_last;

	task automatic half();
		repeat (4) @(posedge mclk);
	endtask

	// byte k of w and r sits at bits 8k+7:8k; read bits sampled late
	task automatic frame(input logic rd, input logic lsb, input logic so,
		input logic [12:0] a, input int nb, input logic [23:0] w,
		output logic [23:0] r);
		logic [15:0] ins;
		int k;
		ins = {rd, 2'b00, a};
		r = 24'h000000;
		csb_n <= 1'b0;
		half();
		for (int i = 0; i < 16 + 8 * nb; i++) begin
			k = (i < 16) ? 0 : 8 * ((i - 16) / 8) + (lsb ? (i % 8) : 7 - i % 8);
			drv <= !(rd && i >= 16);
			wbit <= (i < 16) ? ins[lsb ? i : 15 - i] : w[k];
			sclk <= 1'b0;
			half();
			sclk <= 1'b1;
			half();
			if (rd && i >= 16) begin
				r[k] = so ? so_line : sdio_in;
			end
		end
		sclk <= 1'b0;
		half();
		csb_n <= 1'b1;
		drv <= 1'b0;
		half();
	endtask
endmodule

`default_nettype wire

// *** tb/serial_port_config_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module serial_port_config_regs_tb;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic i2c_mode = 1'b0;
	logic io_update = 1'b0;
	logic sclk, csb_n, sdio_in, sdio_out, sdio_oe, so_out, so_oe;
	logic bank_active, soft_reset_pulse;
	logic [7:0] setup_byte;
	logic [23:0] r;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int so_cnt = 0;
	int sd_cnt = 0;
	int pl_cnt = 0;
	int so_b, sd_b, pl_b;

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	spc_regs dut_u (.mclk(mclk), .arst_n(arst_n), .sclk(sclk),
		.csb_n(csb_n), .sdio_in(sdio_in), .i2c_mode(i2c_mode),
		.io_update(io_update), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.serial_output_pin_out(so_out), .serial_output_pin_oe(so_oe),
		.setup_byte(setup_byte), .bank_active(bank_active),
		.soft_reset_pulse(soft_reset_pulse));

	spc_host host_u (.mclk(mclk), .sclk(sclk), .csb_n(csb_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.so_out(so_out), .so_oe(so_oe));

	task automatic stop_test();
		if (errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic upd();
		io_update <= 1'b1;
		repeat (4) @(posedge mclk);
		io_update <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic mark();
		so_b = so_cnt;
		sd_b = sd_cnt;
		pl_b = pl_cnt;
	endtask

	always @(posedge mclk) begin
		cyc++;
		so_cnt += (so_oe === 1'b1);
		sd_cnt += (sdio_oe === 1'b1);
		pl_cnt += (soft_reset_pulse === 1'b1);
		if (cyc == 30000) begin
			errors++;
			$display("Error at %0t: run did not finish", $time);
			stop_test();
		end
	end

	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk(setup_byte, 8'h00);
		mark();
		host_u.frame(1, 0, 0, 13'h004, 3, 0, r);
		chk(r, 24'h5A3C00);
		chk(so_cnt == so_b && sd_cnt > sd_b, 1);
		host_u.frame(0, 0, 0, 13'h002, 1, 24'hFF, r);
		host_u.frame(1, 0, 0, 13'h002, 1, 0, r);
		chk(r, 24'h5A);
		host_u.frame(0, 0, 0, 13'h004, 1, 24'h01, r);
		host_u.frame(1, 0, 0, 13'h004, 1, 0, r);
		chk({r[7:0], bank_active}, 9'h002);
		upd();
		chk(bank_active, 1);
		host_u.frame(0, 0, 0, 13'h004, 1, 24'h00, r);
		host_u.frame(1, 0, 0, 13'h004, 1, 0, r);
		chk(r, 24'h01);
		upd();
		host_u.frame(1, 0, 0, 13'h004, 1, 0, r);
		chk({r[7:0], bank_active}, 9'h000);
		host_u.frame(0, 0, 0, 13'h000, 1, 24'h81, r);
		chk(setup_byte, 8'h81);
		mark();
		host_u.frame(1, 0, 1, 13'h003, 1, 0, r);
		chk(r, 24'h3C);
		chk(so_cnt > so_b && sd_cnt == sd_b, 1);
		host_u.frame(0, 0, 0, 13'h000, 1, 24'h42, r);
		host_u.frame(1, 1, 0, 13'h002, 3, 0, r);
		chk(r, 24'h003C5A);
		host_u.frame(0, 1, 0, 13'h004, 1, 24'h01, r);
		mark();
		host_u.frame(0, 1, 0, 13'h000, 1, 24'h66, r);
		host_u.frame(1, 1, 0, 13'h004, 1, 0, r);
		chk(r, 24'h00);
		chk(setup_byte, 8'h42);
		chk(pl_cnt - pl_b, 1);
		i2c_mode <= 1'b1;
		host_u.frame(0, 0, 0, 13'h000, 1, 24'hC3, r);
		chk(setup_byte, 8'hC3);
		mark();
		host_u.frame(1, 0, 0, 13'h003, 1, 0, r);
		chk(r, 24'h3C);
		chk(so_cnt == so_b, 1);
		host_u.frame(0, 0, 0, 13'h004, 1, 24'h01, r);
		host_u.frame(0, 0, 0, 13'h000, 1, 24'hE7, r);
		host_u.frame(1, 0, 0, 13'h004, 1, 0, r);
		chk(r, 24'h00);
		chk(setup_byte, 8'hC3);
		chk(pl_cnt - pl_b, 1);
		stop_test();
	end
endmodule

`default_nettype wire
